/* File: design/cles_pkg.sv */
// Package for the contactless error status block: offsets, bit positions,
// reset values and command codes.
// Assumes a single 50 MHz system clock domain and an AHB-Lite register bus.
package cles_pkg;
   // -------------------------------------------------------------------
   // Register map
   // -------------------------------------------------------------------
   localparam logic [7:0] CLES_ERROR_STATUS_IDX = 8'h06;
   localparam logic [7:0] CLES_ERROR_STATUS_ADDR =
      {CLES_ERROR_STATUS_IDX[5:0], 2'h0};
   localparam logic [7:0] CLES_IRQ_STATUS_ADDR = 8'h40;
   localparam logic [7:0] CLES_IRQ_MASK_ADDR = 8'h44;
   localparam logic [7:0] CLES_CONFIG_ADDR = 8'h48;
   localparam logic [7:0] CLES_ERROR_STATUS_RST = 8'h00;
   localparam logic [7:0] CLES_MASK_RST = 8'h00;
   localparam logic [7:0] CLES_CONFIG_RST = 8'h00;
   // -------------------------------------------------------------------
   // Error status bit positions
   // -------------------------------------------------------------------
   localparam int CLES_BIT_WRITE = 7;
   localparam int CLES_BIT_TEMP = 6;
   localparam int CLES_BIT_FIELD = 5;
   localparam int CLES_BIT_OVFL = 4;
   localparam int CLES_BIT_COLL = 3;
   localparam int CLES_BIT_CRC = 2;
   localparam int CLES_BIT_PARITY = 1;
   localparam int CLES_BIT_FRAME = 0;
   // Bits kept across a command start.
   localparam logic [7:0] CLES_KEEP_ON_CMD = 8'h40;
   // Bits cleared at receiver start-up.
   localparam logic [7:0] CLES_CLR_ON_RX = 8'h0F;
   // -------------------------------------------------------------------
   // Configuration fields
   // -------------------------------------------------------------------
   localparam int CLES_CFG_CRC_EN = 0;
   localparam int CLES_CFG_SYNC = 1;
   localparam int CLES_CFG_INIT = 2;
   localparam int CLES_CFG_ACTIVE = 3;
   localparam logic [1:0] CLES_FRAMING_ACTIVE = 2'h1;
   localparam logic [1:0] CLES_SPEED_106 = 2'h0;
   // -------------------------------------------------------------------
   // Command codes and bus constants
   // -------------------------------------------------------------------
   localparam logic [3:0] CLES_CMD_AUTH = 4'hE;
   localparam logic [3:0] CLES_CMD_AUTO_ANTICOLLISION_COMMAND = 4'hD;
   localparam logic [1:0] CLES_HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] CLES_HTRANS_SEQ = 2'h3;
   localparam logic [2:0] CLES_HSIZE_WORD = 3'h2;
   localparam logic [23:0] CLES_ZERO_PAD = 24'h000000;
endpackage

/* File: design/cles_event_cond.sv */
// Qualifier for the raw error events of the receiver, framing checker,
// command engine, FIFO and temperature sensor.
// Assumes all event inputs are single-cycle pulses synchronous to clk.
`timescale 1ns/1ns
`default_nettype none
module cles_event_cond
   import cles_pkg::*;
(
   input wire logic [3:0] command,
   input wire logic cmd_active,
   input wire logic rf_tx_to_rx_window,
   input wire logic host_fifo_write,
   input wire logic any_fifo_write_full,
   input wire logic temp_overheat,
   input wire logic field_late,
   input wire logic [1:0] rx_framing,
   input wire logic [1:0] tx_framing,
   input wire logic [1:0] rx_speed,
   input wire logic bitwise_anticoll,
   input wire logic bit_collision,
   input wire logic crc_fail,
   input wire logic parity_fail,
   input wire logic sof_bad,
   input wire logic byte_len_bad,
   input wire logic auth_count_bad,
   input wire logic miller_short,
   input wire logic [3:0] cfg,
   output logic [7:0] set_vec
);
   wire logic is_auto_anticollision_command;
   wire logic is_auth;
   wire logic at_106;
   wire logic wr_violation;
   wire logic field_ok;
   wire logic coll_ev;
   wire logic frame_ev;

   assign is_auto_anticollision_command = cmd_active && (command == CLES_CMD_AUTO_ANTICOLLISION_COMMAND);
   assign is_auth = cmd_active && (command == CLES_CMD_AUTH);
   assign at_106 = (rx_speed == CLES_SPEED_106);
   assign wr_violation = host_fifo_write &&
      (is_auto_anticollision_command || is_auth || rf_tx_to_rx_window); // R1
   assign field_ok = cfg[CLES_CFG_ACTIVE] &&
      ((rx_framing == CLES_FRAMING_ACTIVE) ||
       (tx_framing == CLES_FRAMING_ACTIVE)); // R3
   // At any speed other than 106 kbit the flag is forced high.
   assign coll_ev = (bit_collision && bitwise_anticoll && at_106) ||
      !at_106; // R5
   assign frame_ev = (sof_bad && at_106) || // R8
      // Active links at 106 kbit carry no byte length check.
      (byte_len_bad && cfg[CLES_CFG_SYNC] && !at_106) || // R9
      (is_auto_anticollision_command && cfg[CLES_CFG_INIT]) || // R10
      (is_auth && auth_count_bad) || // R11
      miller_short; // R12

   assign set_vec[CLES_BIT_WRITE] = wr_violation;
   assign set_vec[CLES_BIT_TEMP] = temp_overheat; // R2
   assign set_vec[CLES_BIT_FIELD] = field_ok && field_late;
   assign set_vec[CLES_BIT_OVFL] = any_fifo_write_full; // R4
   assign set_vec[CLES_BIT_COLL] = coll_ev;
   assign set_vec[CLES_BIT_CRC] = crc_fail && cfg[CLES_CFG_CRC_EN]; // R6
   assign set_vec[CLES_BIT_PARITY] = parity_fail && at_106; // R7
   assign set_vec[CLES_BIT_FRAME] = frame_ev;
endmodule // cles_event_cond
`default_nettype wire

/* File: design/cles_top.sv */
// Error status register bank with AHB-Lite slave and error interrupt.
// Assumes one 50 MHz clock; all status inputs synchronous to clk.
// How it works
// R1: FIFO write violation flag on host FIFO write in restricted phases.
// R2: Overheat sets overtemperature flag and switches antenna drivers off.
// R3: Field timeout flag only in active mode with framing 01.
// R4: FIFO overflow flag on any write to a full FIFO.
// R5: Bit collision flag; cleared at receiver start; forced high off 106k.
// R6: Checksum fail flag when checking enabled; cleared at receiver start.
// R7: Odd check fail flag on parity failure at 106 kbit.
// R8: Framing violation on bad start of frame at 106 kbit.
// R9: Framing violation on byte length error with sync detect option off 106 kbit.
// R10: Framing violation when auto anticollision runs with initiator set.
// R11: Framing violation on wrong byte count during card authentication.
// R12: Framing violation when Miller decoder sees pulses too close.
// R13: Command start clears all flags but overtemperature; no software set.
// R14: Error status at 06h, resets to 00h, read only.
// R15: Error interrupt request set while any error flag is set.
// R16: Flags stay set until command start or receiver start clears them.
`timescale 1ns/1ns
`default_nettype none
module cles_top
   import cles_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic cmd_start,
   input wire logic [3:0] command,
   input wire logic cmd_active,
   input wire logic rx_start,
   input wire logic rf_tx_to_rx_window,
   input wire logic host_fifo_write,
   input wire logic any_fifo_write_full,
   input wire logic temp_overheat,
   input wire logic field_late,
   input wire logic [1:0] rx_framing,
   input wire logic [1:0] tx_framing,
   input wire logic [1:0] rx_speed,
   input wire logic bitwise_anticoll,
   input wire logic bit_collision,
   input wire logic crc_fail,
   input wire logic parity_fail,
   input wire logic sof_bad,
   input wire logic byte_len_bad,
   input wire logic auth_count_bad,
   input wire logic miller_short,
   output logic antenna_off,
   output logic error_interrupt_request,
   output logic irq
);
   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------
   logic [7:0] error_status;
   logic [7:0] irq_status;
   logic [7:0] irq_mask;
   logic [3:0] cfg;
   logic ph_valid;
   logic ph_write;
   logic [7:0] ph_addr;
   wire logic [7:0] set_vec;
   wire logic [7:0] clr_vec;
   wire logic [7:0] next_error_status;
   wire logic [7:0] next_irq_status;
   wire logic [7:0] w1c;
   wire logic addr_ok;
   wire logic wr_irq_status;
   wire logic wr_irq_mask;
   wire logic wr_cfg;
   wire logic [31:0] next_hrdata;
   wire logic take;
   wire logic [7:0] old_bits;

   // One address compare shared by every register select.
   function automatic logic cles_hit(input logic [7:0] a,
      input logic [7:0] r);
      return a == r;
   endfunction

   cles_event_cond cles_event_cond_inst (
      .command(command),
      .cmd_active(cmd_active),
      .rf_tx_to_rx_window(rf_tx_to_rx_window),
      .host_fifo_write(host_fifo_write),
      .any_fifo_write_full(any_fifo_write_full),
      .temp_overheat(temp_overheat),
      .field_late(field_late),
      .rx_framing(rx_framing),
      .tx_framing(tx_framing),
      .rx_speed(rx_speed),
      .bitwise_anticoll(bitwise_anticoll),
      .bit_collision(bit_collision),
      .crc_fail(crc_fail),
      .parity_fail(parity_fail),
      .sof_bad(sof_bad),
      .byte_len_bad(byte_len_bad),
      .auth_count_bad(auth_count_bad),
      .miller_short(miller_short),
      .cfg(cfg),
      .set_vec(set_vec)
   );

   // -------------------------------------------------------------------
   // Error flags
   // -------------------------------------------------------------------
   // A new event in the clearing cycle wins, so nothing is lost.
   assign clr_vec = (cmd_start ? ~CLES_KEEP_ON_CMD : 8'h00) |
      (rx_start ? CLES_CLR_ON_RX : 8'h00); // R13
   assign next_error_status = (error_status & ~clr_vec) | set_vec; // R16
   // Bits newly raised this cycle feed the interrupt status.
   assign old_bits = error_status;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         error_status <= CLES_ERROR_STATUS_RST; // R14
      end else begin
         error_status <= next_error_status;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         antenna_off <= 1'b0;
         error_interrupt_request <= 1'b0;
      end else begin
         antenna_off <= next_error_status[CLES_BIT_TEMP]; // R2
         error_interrupt_request <= |next_error_status; // R15
      end
   end

   // -------------------------------------------------------------------
   // AHB-Lite slave
   // -------------------------------------------------------------------
   // Only whole-word transfers are taken; narrower ones are ignored.
   assign take = hsel && hready && hsize == CLES_HSIZE_WORD &&
      (htrans == CLES_HTRANS_NONSEQ || htrans == CLES_HTRANS_SEQ);
   assign addr_ok = ph_valid && ph_write;
   assign wr_irq_status = addr_ok && cles_hit(ph_addr, CLES_IRQ_STATUS_ADDR);
   assign wr_irq_mask = addr_ok && cles_hit(ph_addr, CLES_IRQ_MASK_ADDR);
   assign wr_cfg = addr_ok && cles_hit(ph_addr, CLES_CONFIG_ADDR);
   // Error status ignores writes entirely; software can never set it.
   assign w1c = wr_irq_status ? hwdata[7:0] : 8'h00; // R13
   assign next_irq_status = (irq_status & ~w1c) |
      (next_error_status & ~old_bits);

   assign next_hrdata =
      cles_hit(haddr, CLES_ERROR_STATUS_ADDR) ?
         {CLES_ZERO_PAD, next_error_status} : // R14
      cles_hit(haddr, CLES_IRQ_STATUS_ADDR) ?
         {CLES_ZERO_PAD, next_irq_status} :
      cles_hit(haddr, CLES_IRQ_MASK_ADDR) ? {CLES_ZERO_PAD, irq_mask} :
      cles_hit(haddr, CLES_CONFIG_ADDR) ? {CLES_ZERO_PAD, 4'h0, cfg} :
      32'h00000000;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ph_valid <= 1'b0;
         ph_write <= 1'b0;
         ph_addr <= 8'h00;
         hrdata <= 32'h00000000;
      end else begin
         ph_valid <= take;
         ph_write <= hwrite;
         ph_addr <= haddr;
         if (take && !hwrite) begin
            hrdata <= next_hrdata;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // Interrupt and configuration registers
   // -------------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_status <= CLES_ERROR_STATUS_RST;
         irq_mask <= CLES_MASK_RST;
         cfg <= CLES_CONFIG_RST[3:0];
         irq <= 1'b0;
      end else begin
         irq_status <= next_irq_status;
         irq <= |(next_irq_status & (wr_irq_mask ? hwdata[7:0] : irq_mask));
         if (wr_irq_mask) begin
            irq_mask <= hwdata[7:0];
         end
         if (wr_cfg) begin
            cfg <= hwdata[3:0];
         end
      end
   end

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   sequence s_cmd_clear;
      cmd_start && !temp_overheat;
   endsequence

   a_ro_status: assert property (@(posedge clk) disable iff (!arst_n) // R14
      (error_status == 8'h00 && set_vec == 8'h00) |=>
         error_status == 8'h00)
      else $error("error status changed with no event");

   a_cmd_clear: assert property (@(posedge clk) disable iff (!arst_n) // R13
      s_cmd_clear |=> (error_status & ~CLES_KEEP_ON_CMD) ==
         ($past(set_vec) & ~CLES_KEEP_ON_CMD))
      else $error("command start did not clear flags");

   a_temp_keep: assert property (@(posedge clk) disable iff (!arst_n) // R2
      error_status[CLES_BIT_TEMP] && !rx_start |=>
         error_status[CLES_BIT_TEMP])
      else $error("overtemperature flag lost");

   a_temp_ant: assert property (@(posedge clk) disable iff (!arst_n) // R2
      temp_overheat |=> antenna_off && error_status[CLES_BIT_TEMP])
      else $error("antenna not switched off");

   a_ovfl_set: assert property (@(posedge clk) disable iff (!arst_n) // R4
      any_fifo_write_full |=> error_status[CLES_BIT_OVFL])
      else $error("overflow not flagged");

   a_rx_clear: assert property (@(posedge clk) disable iff (!arst_n) // R6
      rx_start && !crc_fail |=> !error_status[CLES_BIT_CRC])
      else $error("checksum flag not cleared at receiver start");

   a_crc_gate: assert property (@(posedge clk) disable iff (!arst_n) // R6
      crc_fail && !cfg[CLES_CFG_CRC_EN] && !error_status[CLES_BIT_CRC]
         |=> !error_status[CLES_BIT_CRC])
      else $error("checksum flag set while disabled");

   a_hold_flags: assert property (@(posedge clk) disable iff (!arst_n) // R16
      !cmd_start && !rx_start |=>
         (error_status & $past(error_status)) == $past(error_status))
      else $error("flag dropped without clear");

   a_irq_req: assert property (@(posedge clk) disable iff (!arst_n) // R15
      error_interrupt_request == (|error_status))
      else $error("error interrupt request mismatch");

   a_coll_fast: assert property (@(posedge clk) disable iff (!arst_n) // R5
      rx_speed != CLES_SPEED_106 |=> error_status[CLES_BIT_COLL])
      else $error("collision flag not high off 106 kbit");

   // -------------------------------------------------------------------
   // Checks per error source, receiver start, bus response and interrupt
   // -------------------------------------------------------------------
   sequence s_fast_sync;
      byte_len_bad && cfg[CLES_CFG_SYNC] && rx_speed != CLES_SPEED_106;
   endsequence

   sequence s_rx_only;
      rx_start && !cmd_start;
   endsequence

   sequence s_ovfl_rise;
      any_fifo_write_full && !error_status[CLES_BIT_OVFL];
   endsequence

   a_write_set: assert property (@(posedge clk) disable iff (!arst_n) // R1
      host_fifo_write && rf_tx_to_rx_window |=>
         error_status[CLES_BIT_WRITE])
      else $error("fifo write violation not flagged");

   a_write_gate: assert property (@(posedge clk) disable iff (!arst_n) // R1
      host_fifo_write && !cmd_active && !rf_tx_to_rx_window &&
         !error_status[CLES_BIT_WRITE] |=> !error_status[CLES_BIT_WRITE])
      else $error("fifo write violation flagged outside window");

   a_field_set: assert property (@(posedge clk) disable iff (!arst_n) // R3
      field_late && cfg[CLES_CFG_ACTIVE] &&
         tx_framing == CLES_FRAMING_ACTIVE |=> error_status[CLES_BIT_FIELD])
      else $error("field timeout not flagged");

   a_field_gate: assert property (@(posedge clk) disable iff (!arst_n) // R3
      field_late && !cfg[CLES_CFG_ACTIVE] && !error_status[CLES_BIT_FIELD]
         |=> !error_status[CLES_BIT_FIELD])
      else $error("field timeout flagged outside active mode");

   a_coll_clear: assert property (@(posedge clk) disable iff (!arst_n) // R5
      rx_start && !bit_collision && rx_speed == CLES_SPEED_106 |=>
         !error_status[CLES_BIT_COLL])
      else $error("collision flag not cleared at receiver start");

   a_crc_set: assert property (@(posedge clk) disable iff (!arst_n) // R6
      crc_fail && cfg[CLES_CFG_CRC_EN] |=> error_status[CLES_BIT_CRC])
      else $error("checksum failure not flagged");

   a_parity_set: assert property (@(posedge clk) disable iff (!arst_n) // R7
      parity_fail && rx_speed == CLES_SPEED_106 |=>
         error_status[CLES_BIT_PARITY])
      else $error("parity failure not flagged");

   a_parity_gate: assert property (@(posedge clk) disable iff (!arst_n) // R7
      parity_fail && rx_speed != CLES_SPEED_106 &&
         !error_status[CLES_BIT_PARITY] |=> !error_status[CLES_BIT_PARITY])
      else $error("parity flag set off 106 kbit");

   a_sof_set: assert property (@(posedge clk) disable iff (!arst_n) // R8
      sof_bad && rx_speed == CLES_SPEED_106 |=>
         error_status[CLES_BIT_FRAME])
      else $error("bad start of frame not flagged");

   a_sync_len: assert property (@(posedge clk) disable iff (!arst_n) // R9
      s_fast_sync |=> error_status[CLES_BIT_FRAME])
      else $error("byte length violation not flagged");

   a_init_role: assert property (@(posedge clk) disable iff (!arst_n) // R10
      cmd_active && command == CLES_CMD_AUTO_ANTICOLLISION_COMMAND && cfg[CLES_CFG_INIT]
         |=> error_status[CLES_BIT_FRAME])
      else $error("initiator role in anticollision not flagged");

   a_auth_count: assert property (@(posedge clk) disable iff (!arst_n) // R11
      cmd_active && command == CLES_CMD_AUTH && auth_count_bad |=>
         error_status[CLES_BIT_FRAME])
      else $error("authentication byte count not flagged");

   a_miller_pulse: assert property (@(posedge clk) disable iff (!arst_n) // R12
      miller_short |=> error_status[CLES_BIT_FRAME])
      else $error("short pulse spacing not flagged");

   a_rx_keep: assert property (@(posedge clk) disable iff (!arst_n) // R16
      s_rx_only |=> (error_status & $past(error_status) & ~CLES_CLR_ON_RX)
         == ($past(error_status) & ~CLES_CLR_ON_RX))
      else $error("receiver start dropped an upper flag");

   a_okay_resp: assert property (@(posedge clk) disable iff (!arst_n) // R14
      hreadyout && !hresp)
      else $error("bus response not ready and okay");

   a_irq_level: assert property (@(posedge clk) disable iff (!arst_n) // R15
      irq == (|(irq_status & irq_mask)))
      else $error("interrupt output does not follow masked status");

   a_irq_rise: assert property (@(posedge clk) disable iff (!arst_n) // R15
      s_ovfl_rise |=> irq_status[CLES_BIT_OVFL])
      else $error("rising error bit missed by interrupt status");
endmodule // cles_top
`default_nettype wire

/* File: verif/cles_host_model.sv */
// Host controller model: single AHB-Lite word transfers to the status bank.
// Assumes one slave whose hreadyout comes back as hready.
`timescale 1ns/1ns
`default_nettype none
module cles_host_model
   import cles_pkg::*;
(
   input wire logic clk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   output var logic hsel,
   output var logic [7:0] haddr,
   output var logic [1:0] htrans,
   output var logic hwrite,
   output var logic [2:0] hsize,
   output var logic [31:0] hwdata,
   output var logic hang
);
   // ------------------------------------------------------------------
   // Bus transfers
   // ------------------------------------------------------------------
   initial begin
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = CLES_HSIZE_WORD;
      hwdata = 32'h00000000;
      hang = 1'b0;
   end
   // The wait is bounded, so a dead slave flags a hang instead of stalling.
   task automatic wait_ready();
      int i;
      for (i = 0; i < 16; i++) begin
         @(posedge clk);
         if (hready === 1'b1) break;
      end
      if (i == 16) hang <= 1'b1;
   endtask
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= CLES_HTRANS_NONSEQ;
      hwrite <= w;
      hwdata <= ~hwdata;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      haddr <= ~a;
      hwdata <= d;
      wait_ready();
      q = hrdata;
   endtask
endmodule // cles_host_model
`default_nettype wire

/* File: verif/contactless_error_status_test.sv */
// Self-checking bench for the error status bank.
// Assumes the host model drives the bus and events are pulsed here.
`timescale 1ns/1ns
`default_nettype none
module contactless_error_status_test
   import cles_pkg::*;
;
   logic clk, arst_n, hsel, hwrite, hreadyout, hresp, hang;
   logic [7:0] haddr;
   logic [1:0] htrans, rx_framing, tx_framing, rx_speed;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata;
   logic [3:0] command;
   logic cmd_start, cmd_active, rx_start, rf_tx_to_rx_window;
   logic host_fifo_write, any_fifo_write_full, temp_overheat, field_late;
   logic bitwise_anticoll, bit_collision, crc_fail, parity_fail, sof_bad;
   logic byte_len_bad, auth_count_bad, miller_short;
   logic antenna_off, error_interrupt_request, irq;
   int n_mismatch = 0;
   int check_count = 0;
   cles_top cles_top_inst (.clk(clk), .arst_n(arst_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .cmd_start(cmd_start),
      .command(command), .cmd_active(cmd_active), .rx_start(rx_start),
      .rf_tx_to_rx_window(rf_tx_to_rx_window),
      .host_fifo_write(host_fifo_write),
      .any_fifo_write_full(any_fifo_write_full),
      .temp_overheat(temp_overheat), .field_late(field_late),
      .rx_framing(rx_framing), .tx_framing(tx_framing),
      .rx_speed(rx_speed), .bitwise_anticoll(bitwise_anticoll),
      .bit_collision(bit_collision), .crc_fail(crc_fail),
      .parity_fail(parity_fail), .sof_bad(sof_bad),
      .byte_len_bad(byte_len_bad), .auth_count_bad(auth_count_bad),
      .miller_short(miller_short), .antenna_off(antenna_off),
      .error_interrupt_request(error_interrupt_request), .irq(irq));
   cles_host_model cles_host_model_inst (.clk(clk), .hready(hreadyout),
      .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hang(hang));
   // ------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      cles_host_model_inst.xfer(1'b1, a, d, q);
   endtask
   task automatic chk(input string nm, input logic [7:0] a,
                      input logic [31:0] exp);
      logic [31:0] q;
      cles_host_model_inst.xfer(1'b0, a, 32'h00000000, q);
      check(nm, q, exp);
      check("hresp", hresp, 1'b0);
   endtask
   task automatic err(input logic [7:0] e);
      chk("error_status", CLES_ERROR_STATUS_ADDR, {24'h000000, e});
      check("err_irq", error_interrupt_request, e != 8'h00);
   endtask
   task automatic drv(input int k, input logic v);
      case (k)
         0: crc_fail <= v;
         1: parity_fail <= v;
         2: sof_bad <= v;
         3: bit_collision <= v;
         4: host_fifo_write <= v;
         5: any_fifo_write_full <= v;
         6: field_late <= v;
         7: temp_overheat <= v;
         8: rx_start <= v;
         9: cmd_start <= v;
         10: byte_len_bad <= v;
         11: auth_count_bad <= v;
         default: miller_short <= v;
      endcase
   endtask
   task automatic pulse(input int k);
      @(posedge clk);
      drv(k, 1'b1);
      @(posedge clk);
      drv(k, 1'b0);
      @(posedge clk);
   endtask
   task automatic do_reset();
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // ------------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------------
   initial begin
      arst_n = 1'b0;
      {cmd_start, cmd_active, rx_start, rf_tx_to_rx_window} = 4'h0;
      {host_fifo_write, any_fifo_write_full, temp_overheat} = 3'h0;
      {field_late, bitwise_anticoll, bit_collision, crc_fail} = 4'h0;
      {parity_fail, sof_bad, byte_len_bad, auth_count_bad} = 4'h0;
      miller_short = 1'b0;
      command = 4'h0;
      {rx_framing, tx_framing, rx_speed} = 6'h00;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      check("antenna_off", antenna_off, 1'b0);
      err(8'h00);
      wr(CLES_ERROR_STATUS_ADDR, 32'h000000FF);
      err(8'h00);
      chk("unmapped", 8'h7C, 32'h00000000);
      pulse(0);
      err(8'h00);
      wr(CLES_CONFIG_ADDR, 32'h00000001);
      pulse(0);
      err(8'h04);
      bitwise_anticoll <= 1'b1;
      pulse(3);
      err(8'h0C);
      pulse(1);
      err(8'h0E);
      pulse(2);
      err(8'h0F);
      chk("irq_status", CLES_IRQ_STATUS_ADDR, 32'h0000000F);
      check("irq", irq, 1'b0);
      wr(CLES_IRQ_MASK_ADDR, 32'h00000004);
      repeat (2) @(posedge clk);
      check("irq", irq, 1'b1);
      wr(CLES_IRQ_STATUS_ADDR, 32'h000000FF);
      repeat (2) @(posedge clk);
      check("irq", irq, 1'b0);
      chk("irq_status", CLES_IRQ_STATUS_ADDR, 32'h00000000);
      pulse(8);
      err(8'h00);
      pulse(4);
      err(8'h00);
      rf_tx_to_rx_window <= 1'b1;
      pulse(4);
      rf_tx_to_rx_window <= 1'b0;
      err(8'h80);
      pulse(5);
      err(8'h90);
      pulse(6);
      err(8'h90);
      rx_framing <= CLES_FRAMING_ACTIVE;
      wr(CLES_CONFIG_ADDR, 32'h00000008);
      pulse(6);
      err(8'hB0);
      pulse(8);
      err(8'hB0);
      pulse(7);
      err(8'hF0);
      check("antenna_off", antenna_off, 1'b1);
      pulse(9);
      err(8'h40);
      do_reset();
      err(8'h00);
      command <= CLES_CMD_AUTO_ANTICOLLISION_COMMAND;
      cmd_active <= 1'b1;
      wr(CLES_CONFIG_ADDR, 32'h00000004);
      repeat (2) @(posedge clk);
      err(8'h01);
      pulse(4);
      err(8'h81);
      cmd_active <= 1'b0;
      pulse(9);
      err(8'h00);
      command <= CLES_CMD_AUTH;
      cmd_active <= 1'b1;
      wr(CLES_CONFIG_ADDR, 32'h00000000);
      pulse(11);
      err(8'h01);
      cmd_active <= 1'b0;
      pulse(9);
      pulse(12);
      err(8'h01);
      pulse(9);
      wr(CLES_CONFIG_ADDR, 32'h00000002);
      rx_speed <= 2'h1;
      pulse(10);
      err(8'h09);
      pulse(8);
      err(8'h08);
      pulse(2);
      pulse(1);
      err(8'h08);
      rx_speed <= CLES_SPEED_106;
      wr(CLES_CONFIG_ADDR, 32'h0000000A);
      pulse(9);
      pulse(10);
      err(8'h00);
      rx_framing <= 2'h0;
      tx_framing <= CLES_FRAMING_ACTIVE;
      pulse(6);
      err(8'h20);
      cmd_active <= 1'b1;
      pulse(4);
      cmd_active <= 1'b0;
      err(8'hA0);
      check("bus_hang", hang, 1'b0);
      summarize();
   end
endmodule // contactless_error_status_test
`default_nettype wire
